//--- fsh_pkg.sv
package fsh_pkg;
	// wishbone register byte offsets
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_ADDR = 5'h04;
	localparam logic [4:0] REG_WDATA = 5'h08;
	localparam logic [4:0] REG_RDATA = 5'h0c;
	localparam logic [4:0] REG_STATUS = 5'h10;
	// control and status register fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_DIE_BIT = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_READY_BIT = 1;
	// operation codes
	localparam logic [2:0] OP_ARRAY_RD = 3'h1;
	localparam logic [2:0] OP_CMD_WR = 3'h2;
	localparam logic [2:0] OP_ERASE = 3'h3;
	localparam logic [2:0] OP_DIE_RD = 3'h4;
	localparam logic [2:0] OP_RESET = 3'h5;
	// flash address layout
	localparam int ADDR_W = 27;
	localparam int DATA_W = 16;
	localparam int DIE_BIT = 26;
	localparam int SECTOR_LSB = 16;
	// flash command words
	localparam logic [10:0] UNLOCK1_ADDR = 11'h555;
	localparam logic [10:0] UNLOCK2_ADDR = 11'h2aa;
	localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
	localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
	localparam logic [15:0] ERASE_SETUP = 16'h0080;
	localparam logic [15:0] SECTOR_ERASE = 16'h0030;
	localparam logic [2:0] ERASE_LAST_STEP = 3'h5;
	// identification word offsets from a die base
	localparam logic [7:0] ID_MAKER = 8'h00;
	localparam logic [7:0] ID_PART1 = 8'h01;
	localparam logic [7:0] ID_LOCK = 8'h02;
	localparam logic [7:0] ID_SECURE = 8'h03;
	localparam logic [7:0] ID_PART2 = 8'h0e;
	localparam logic [7:0] ID_PART3 = 8'h0f;
	// timing
	localparam int CLK_NS = 25;
	localparam int ACC_NS = 110;
	localparam int WP_NS = 50;
	localparam int RP_NS = 200;
	localparam int RPH_NS = 35000;
	localparam int SYNC_CYC = 2;
	localparam logic [11:0] ACC_CYC = 12'((ACC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] WP_CYC = 12'((WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] RP_CYC = 12'((RP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] RPH_CYC = 12'((RPH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] RD_CYC = 12'(ACC_CYC + 12'(SYNC_CYC));

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SETUP = 6'h02,
		ST_PULSE = 6'h04,
		ST_HOLD = 6'h08,
		ST_RST_LO = 6'h10,
		ST_RST_REC = 6'h20
	} fsh_state_type;

	typedef struct packed {
		fsh_state_type state;
		logic [2:0] op;
		logic die;
		logic [2:0] step;
		logic [11:0] cnt;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] dq_s1;
		logic [DATA_W-1:0] dq_s2;
		logic rdy_s1;
		logic rdy_s2;
		logic ack;
		logic [31:0] wb_dat;
		logic [ADDR_W-1:0] fl_addr;
		logic [DATA_W-1:0] fl_dq;
		logic fl_dq_oe_n;
		logic fl_ce_n;
		logic fl_oe_n;
		logic fl_we_n;
		logic fl_reset_n;
	} fsh_regs_type;
endpackage

//--- fsh_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - host adds die base offset, zero or die bit set, to commands
// - sector erase is six writes to the chosen die ending 30h at sector
// - both unlock writes carry the die bit of the intended die
// - command address arguments are steered to the die by die bit
// - response reads such as status or id also carry the die bit
module fsh_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [26:0] fl_addr_o,
	output logic [15:0] fl_dq_o,
	output logic fl_dq_oe_n_o,
	input wire logic [15:0] fl_dq_i,
	output logic fl_ce_n_o,
	output logic fl_oe_n_o,
	output logic fl_we_n_o,
	output logic fl_reset_n_o,
	input wire logic fl_ready_i
);
	fsh_pkg::fsh_regs_type s_ff, nxt_s;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic req;
		logic is_wr;
		logic [26:0] die_addr;
		logic [26:0] cur_addr;
		logic [15:0] cur_data;
		req = 1'b0;
		is_wr = 1'b0;
		die_addr = '0;
		cur_addr = '0;
		cur_data = '0;
		nxt_s = s_ff;
		// pins cross in through two flops before use
		nxt_s.dq_s1 = fl_dq_i;
		nxt_s.dq_s2 = s_ff.dq_s1;
		nxt_s.rdy_s1 = fl_ready_i;
		nxt_s.rdy_s2 = s_ff.rdy_s1;
		nxt_s.ack = 1'b0;
		req = wb_cyc_i && wb_stb_i && !s_ff.ack;

		// die base offset replaces the top address bit
		die_addr = {s_ff.die, s_ff.addr[25:0]};
		is_wr = (s_ff.op == fsh_pkg::OP_CMD_WR) ||
			(s_ff.op == fsh_pkg::OP_ERASE);
		unique case (s_ff.op)
		fsh_pkg::OP_ARRAY_RD: begin
			cur_addr = s_ff.addr;
		end
		fsh_pkg::OP_ERASE: begin
			unique case (s_ff.step)
			3'h0, 3'h3: begin
				cur_addr = {s_ff.die, 15'h0000, fsh_pkg::UNLOCK1_ADDR};
				cur_data = fsh_pkg::UNLOCK1_DATA;
			end
			3'h1, 3'h4: begin
				cur_addr = {s_ff.die, 15'h0000, fsh_pkg::UNLOCK2_ADDR};
				cur_data = fsh_pkg::UNLOCK2_DATA;
			end
			3'h2: begin
				cur_addr = {s_ff.die, 15'h0000, fsh_pkg::UNLOCK1_ADDR};
				cur_data = fsh_pkg::ERASE_SETUP;
			end
			default: begin
				// sector base: low sixteen word bits cleared
				cur_addr = {die_addr[26:16], 16'h0000};
				cur_data = fsh_pkg::SECTOR_ERASE;
			end
			endcase
		end
		default: begin
			// single command write or response read on one die
			cur_addr = die_addr;
			cur_data = s_ff.wdata;
		end
		endcase

		// register slave, one wait state per access
		if (req) begin
			nxt_s.ack = 1'b1;
			nxt_s.wb_dat = '0;
			unique case (wb_adr_i)
			fsh_pkg::REG_CTRL: begin
				nxt_s.wb_dat[fsh_pkg::CTRL_OP_LSB +: 3] = s_ff.op;
				nxt_s.wb_dat[fsh_pkg::CTRL_DIE_BIT] = s_ff.die;
			end
			fsh_pkg::REG_ADDR: nxt_s.wb_dat[26:0] = s_ff.addr;
			fsh_pkg::REG_WDATA: nxt_s.wb_dat[15:0] = s_ff.wdata;
			fsh_pkg::REG_RDATA: nxt_s.wb_dat[15:0] = s_ff.rdata;
			fsh_pkg::REG_STATUS: begin
				nxt_s.wb_dat[fsh_pkg::STAT_BUSY_BIT] =
					(s_ff.state != fsh_pkg::ST_IDLE);
				nxt_s.wb_dat[fsh_pkg::STAT_READY_BIT] = s_ff.rdy_s2;
			end
			default: nxt_s.wb_dat = '0;
			endcase
			// setup registers are locked while an operation runs
			if (wb_we_i && s_ff.state == fsh_pkg::ST_IDLE) begin
				if (wb_adr_i == fsh_pkg::REG_ADDR)
					nxt_s.addr = wb_dat_i[26:0];
				if (wb_adr_i == fsh_pkg::REG_WDATA)
					nxt_s.wdata = wb_dat_i[15:0];
				if (wb_adr_i == fsh_pkg::REG_CTRL) begin
					nxt_s.op = wb_dat_i[fsh_pkg::CTRL_OP_LSB +: 3];
					nxt_s.die = wb_dat_i[fsh_pkg::CTRL_DIE_BIT];
					nxt_s.step = 3'h0;
					if (wb_dat_i[2:0] == fsh_pkg::OP_RESET) begin
						nxt_s.state = fsh_pkg::ST_RST_LO;
						nxt_s.fl_reset_n = 1'b0;
						nxt_s.cnt = 12'(fsh_pkg::RP_CYC - 12'h001);
					end else if (wb_dat_i[2:0] >= fsh_pkg::OP_ARRAY_RD &&
						wb_dat_i[2:0] <= fsh_pkg::OP_DIE_RD) begin
						nxt_s.state = fsh_pkg::ST_SETUP;
					end
				end
			end
		end

		////////////////////////////////////////////////////////////////////
		unique case (s_ff.state)
		fsh_pkg::ST_IDLE: begin
			// address stays put while idle so the flash may sleep
			nxt_s.fl_ce_n = 1'b1;
		end
		fsh_pkg::ST_SETUP: begin
			// one shared select: the die bit alone picks the die
			nxt_s.fl_addr = cur_addr;
			nxt_s.fl_ce_n = 1'b0;
			nxt_s.state = fsh_pkg::ST_PULSE;
			if (is_wr) begin
				nxt_s.fl_dq = cur_data;
				nxt_s.fl_dq_oe_n = 1'b0;
				nxt_s.fl_we_n = 1'b0;
				nxt_s.cnt = 12'(fsh_pkg::WP_CYC - 12'h001);
			end else begin
				// host releases data so only one die drives it
				nxt_s.fl_dq_oe_n = 1'b1;
				nxt_s.fl_oe_n = 1'b0;
				// two extra cycles cover the input synchroniser
				nxt_s.cnt = 12'(fsh_pkg::RD_CYC - 12'h001);
			end
		end
		fsh_pkg::ST_PULSE: begin
			if (s_ff.cnt == 12'h000) begin
				if (!is_wr)
					nxt_s.rdata = s_ff.dq_s2;
				nxt_s.fl_we_n = 1'b1;
				nxt_s.fl_oe_n = 1'b1;
				nxt_s.state = fsh_pkg::ST_HOLD;
			end else begin
				nxt_s.cnt = 12'(s_ff.cnt - 12'h001);
			end
		end
		fsh_pkg::ST_HOLD: begin
			// data held one cycle past the rising write strobe
			nxt_s.fl_ce_n = 1'b1;
			nxt_s.fl_dq_oe_n = 1'b1;
			if (s_ff.op == fsh_pkg::OP_ERASE &&
				s_ff.step != fsh_pkg::ERASE_LAST_STEP) begin
				nxt_s.step = 3'(s_ff.step + 3'h1);
				nxt_s.state = fsh_pkg::ST_SETUP;
			end else begin
				nxt_s.state = fsh_pkg::ST_IDLE;
			end
		end
		fsh_pkg::ST_RST_LO: begin
			if (s_ff.cnt == 12'h000) begin
				nxt_s.fl_reset_n = 1'b1;
				nxt_s.cnt = 12'(fsh_pkg::RPH_CYC - 12'h001);
				nxt_s.state = fsh_pkg::ST_RST_REC;
			end else begin
				nxt_s.cnt = 12'(s_ff.cnt - 12'h001);
			end
		end
		fsh_pkg::ST_RST_REC: begin
			// no access until the recovery interval has run out
			if (s_ff.cnt == 12'h000)
				nxt_s.state = fsh_pkg::ST_IDLE;
			else
				nxt_s.cnt = 12'(s_ff.cnt - 12'h001);
		end
		default: nxt_s.state = fsh_pkg::ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_ff <= '{state: fsh_pkg::ST_IDLE, op: 3'h0, die: 1'b0,
				step: 3'h0, cnt: 12'h000, addr: 27'h0000000,
				wdata: 16'h0000, rdata: 16'h0000, dq_s1: 16'h0000,
				dq_s2: 16'h0000, rdy_s1: 1'b0, rdy_s2: 1'b0, ack: 1'b0,
				wb_dat: 32'h00000000, fl_addr: 27'h0000000,
				fl_dq: 16'h0000, fl_dq_oe_n: 1'b1, fl_ce_n: 1'b1,
				fl_oe_n: 1'b1, fl_we_n: 1'b1, fl_reset_n: 1'b1};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign wb_dat_o = s_ff.wb_dat;
	assign wb_ack_o = s_ff.ack;
	assign fl_addr_o = s_ff.fl_addr;
	assign fl_dq_o = s_ff.fl_dq;
	assign fl_dq_oe_n_o = s_ff.fl_dq_oe_n;
	assign fl_ce_n_o = s_ff.fl_ce_n;
	assign fl_oe_n_o = s_ff.fl_oe_n;
	assign fl_we_n_o = s_ff.fl_we_n;
	assign fl_reset_n_o = s_ff.fl_reset_n;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_single_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	strobe_excl_a: assert property (!(!fl_we_n_o && !fl_oe_n_o))
		else $error("write and read strobes low together");
	write_drives_a: assert property (!fl_we_n_o |-> !fl_dq_oe_n_o)
		else $error("write strobe low without data driven");
	read_releases_a: assert property (!fl_oe_n_o |-> fl_dq_oe_n_o)
		else $error("data driven during a read");
	die_bit_a: assert property ((!fl_ce_n_o && s_ff.op != 3'h1)
		|-> fl_addr_o[26] == s_ff.die)
		else $error("die bit differs from chosen die");
	unlock_first_a: assert property ($fell(fl_we_n_o) &&
		s_ff.op == 3'h3 && s_ff.step == 3'h0
		|-> fl_addr_o[10:0] == 11'h555 && fl_dq_o == 16'h00aa)
		else $error("first unlock write wrong");
	erase_final_a: assert property ($fell(fl_we_n_o) &&
		s_ff.op == 3'h3 && s_ff.step == 3'h5
		|-> fl_dq_o == 16'h0030 && fl_addr_o[15:0] == 16'h0000)
		else $error("erase command word or sector address wrong");
	array_addr_a: assert property ($fell(fl_oe_n_o) &&
		s_ff.op == 3'h1 |-> fl_addr_o == s_ff.addr)
		else $error("array read address altered");
	we_width_a: assert property ($fell(fl_we_n_o)
		|-> !fl_we_n_o[*2] ##1 fl_we_n_o)
		else $error("write strobe width wrong");
	oe_width_a: assert property ($fell(fl_oe_n_o)
		|-> !fl_oe_n_o[*7] ##1 fl_oe_n_o)
		else $error("read strobe width wrong");
	reset_width_a: assert property ($fell(fl_reset_n_o)
		|-> !fl_reset_n_o[*8] ##1 fl_reset_n_o)
		else $error("reset pulse width wrong");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o)
		else $error("request not answered next cycle");
	unlock_second_a: assert property ($fell(fl_we_n_o) &&
		s_ff.op == 3'h3 && s_ff.step == 3'h1
		|-> fl_addr_o[10:0] == 11'h2aa && fl_dq_o == 16'h0055)
		else $error("second unlock write wrong");
	erase_setup_a: assert property ($fell(fl_we_n_o) &&
		s_ff.op == 3'h3 && s_ff.step == 3'h2
		|-> fl_addr_o[10:0] == 11'h555 && fl_dq_o == 16'h0080)
		else $error("erase setup write wrong");
	write_hold_a: assert property ($rose(fl_we_n_o)
		|-> !fl_ce_n_o && !fl_dq_oe_n_o)
		else $error("select or data dropped with write strobe");
	read_capture_a: assert property ($rose(fl_oe_n_o)
		|-> s_ff.rdata == $past(s_ff.dq_s2))
		else $error("read word not captured at strobe end");
	idle_addr_a: assert property (s_ff.state == fsh_pkg::ST_IDLE
		|=> $stable(fl_addr_o))
		else $error("address moved while idle");
	reset_quiet_a: assert property (!fl_reset_n_o |-> fl_ce_n_o)
		else $error("flash selected during reset pulse");
	recovery_wait_a: assert property (
		s_ff.state == fsh_pkg::ST_RST_REC |-> fl_reset_n_o && fl_ce_n_o)
		else $error("access during reset recovery");

	erase_done_c: cover property (s_ff.op == 3'h3 && s_ff.step == 3'h5 &&
		s_ff.state == fsh_pkg::ST_HOLD);
	array_read_c: cover property (s_ff.op == 3'h1 && $rose(fl_oe_n_o));
	cmd_write_c: cover property (s_ff.op == 3'h2 && $rose(fl_we_n_o));
	die_read_c: cover property (s_ff.op == 3'h4 && s_ff.die &&
		$rose(fl_oe_n_o));
	reset_done_c: cover property (s_ff.state == fsh_pkg::ST_RST_REC &&
		s_ff.cnt == 12'h000);
endmodule
`default_nettype wire

//--- fsh_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsh_flash_model #(
	parameter logic [15:0] MAKER = 16'h00a5,
	parameter logic [15:0] PART1 = 16'h1111,
	parameter logic [15:0] PART2 = 16'h2222,
	parameter logic [15:0] PART3 = 16'h3333,
	parameter logic [15:0] IND = 16'hff3f,
	parameter int ACC_NS = 100,
	parameter int BUSY_CYC = 5000,
	parameter int SLEEP_NS = 140
) (
	input wire logic clk_i,
	input wire logic [26:0] fl_addr_i,
	input wire logic [15:0] fl_dq_i,
	output logic [15:0] fl_dq_o,
	input wire logic fl_ce_n_i,
	input wire logic fl_oe_n_i,
	input wire logic fl_we_n_i,
	input wire logic fl_reset_n_i,
	output logic fl_ready_o
);
	logic [42:0] wq[$];
	logic [1:0] idm = 2'b00;
	logic [15:0] val;
	logic [15:0] last = 16'h0;
	logic [10:0] sec;
	logic ok = 1'b0;
	logic asleep = 1'b0;
	int busy = 0;
	////////////////////////////////////////////////////////////////////
	// one shared select: both dies see each write, die bit picks taker
	always @(posedge fl_we_n_i) begin
		if (!fl_ce_n_i && fl_reset_n_i) begin
			wq.push_back({fl_addr_i, fl_dq_i});
			if (fl_dq_i == 16'h0090)
				idm[fl_addr_i[26]] = 1'b1;
			if (fl_dq_i == 16'h00f0)
				idm[fl_addr_i[26]] = 1'b0;
			if (fl_dq_i == 16'h0030)
				busy = BUSY_CYC;
		end
	end
	always @(posedge clk_i) begin
		if (!fl_reset_n_i)
			busy = 0;
		else if (busy > 0)
			busy = busy - 1;
	end
	assign fl_ready_o = (busy == 0);
	////////////////////////////////////////////////////////////////////
	always @* begin
		sec = fl_addr_i[26:16];
		val = fl_addr_i[15:0] ^ {5'h0, sec};
		if (idm[fl_addr_i[26]]) begin
			case (fl_addr_i[15:0])
				16'h0: val = MAKER;
				16'h1: val = PART1;
				16'h2: val = {15'h0, sec[0]};
				16'h3: val = IND;
				16'he: val = PART2;
				16'hf: val = PART3;
				default: val = 16'hffff;
			endcase
		end
	end
	// slow answer; idle bus shows junk, not the last word
	always @(fl_addr_i or fl_ce_n_i or fl_oe_n_i) begin
		ok = 1'b0;
		#(ACC_NS) ok = !fl_ce_n_i && !fl_oe_n_i;
	end
	always @(posedge clk_i)
		if (ok)
			last <= val;
	assign fl_dq_o = ok ? val : ~last;
	// quiet address drops to sleep, standby until next cycle
	always @(fl_addr_i or fl_reset_n_i) begin
		asleep = 1'b0;
		#(SLEEP_NS) asleep = 1'b1;
	end
endmodule
`default_nettype wire

//--- fsh_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fsh_ctrl_tb;
	// arbitrary identity values
	localparam logic [15:0] MK = 16'h00a5;
	localparam logic [15:0] P1 = 16'h1234;
	localparam logic [15:0] P2 = 16'h5678;
	localparam logic [15:0] P3 = 16'h9abc;
	localparam logic [15:0] IND = 16'hff3f;
	logic clk_i, rst_i, cyc, stb, we, d;
	logic [4:0] adr;
	logic [31:0] dat, rd;
	logic [26:0] a;
	logic [15:0] w;
	int err_total = 0;
	int comparisons = 0;
	logic [42:0] exp_q[$];
	logic [10:0] ea[5] = '{11'h555, 11'h2aa, 11'h555, 11'h555, 11'h2aa};
	logic [15:0] ed[5] = '{16'haa, 16'h55, 16'h80, 16'haa, 16'h55};
	logic [7:0] io[6] = '{8'h0, 8'h1, 8'h2, 8'h3, 8'he, 8'hf};
	wire logic [31:0] wb_dat_o;
	wire logic [26:0] fa;
	wire logic [15:0] cdq, mdq, dq;
	wire logic ack, dq_oe_n, ce_n, oe_n, we_n, rst_n, rdy;
	assign dq = !dq_oe_n ? cdq : mdq;
	fsh_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack),
		.fl_addr_o(fa), .fl_dq_o(cdq), .fl_dq_oe_n_o(dq_oe_n),
		.fl_dq_i(dq), .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n),
		.fl_we_n_o(we_n), .fl_reset_n_o(rst_n), .fl_ready_i(rdy));
	fsh_flash_model #(.MAKER(MK), .PART1(P1), .PART2(P2), .PART3(P3),
		.IND(IND)) flash (.clk_i(clk_i), .fl_addr_i(fa), .fl_dq_i(dq),
		.fl_dq_o(mdq), .fl_ce_n_i(ce_n), .fl_oe_n_i(oe_n),
		.fl_we_n_i(we_n), .fl_reset_n_i(rst_n), .fl_ready_o(rdy));
	////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// request held until the edge that sees ack
	task automatic wb(input logic wr, input logic [4:0] ad,
		input logic [31:0] wd, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= ad;
		dat <= wd;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic run(input logic [2:0] op, input logic [26:0] ad,
		input logic [15:0] wd);
		wb(1'b1, fsh_pkg::REG_ADDR, 32'(ad), rd);
		wb(1'b1, fsh_pkg::REG_WDATA, 32'(wd), rd);
		wb(1'b1, fsh_pkg::REG_CTRL, {23'h0, d, 5'h0, op}, rd);
		do
			wb(1'b0, fsh_pkg::REG_STATUS, 32'h0, rd);
		while (rd[0] !== 1'b0);
	endtask
	task automatic chk_q();
		check("count", 64'(flash.wq.size()), 64'(exp_q.size()));
		while (exp_q.size() > 0 && flash.wq.size() > 0)
			check("write", 64'(flash.wq.pop_front()), 64'(exp_q.pop_front()));
		flash.wq.delete();
		exp_q.delete();
	endtask
	function automatic logic [15:0] idv(input logic [7:0] o, input logic s);
		case (o)
			8'h0: return MK;
			8'h1: return P1;
			8'h2: return {15'h0, s};
			8'h3: return IND;
			8'he: return P2;
			default: return P3;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// whole run needs under ten thousand cycles
	initial begin
		#1000000;
		err_total++;
		report_and_stop();
	end
	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 5'h0;
		dat = 32'h0;
		d = 1'b0;
		void'($urandom(32'h339a));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i); // ready bit trails pin by two flops
		wb(1'b0, fsh_pkg::REG_STATUS, 32'h0, rd);
		check("status", 64'(rd), 64'h2);
		wb(1'b0, 5'h14, 32'h0, rd);
		check("unmapped", 64'(rd), 64'h0);
		$display("test idle done");
		for (int i = 0; i < 2; i++) begin
			d = i[0];
			a = 27'($urandom());
			for (int k = 0; k < 5; k++)
				exp_q.push_back({d, 15'h0, ea[k], ed[k]});
			exp_q.push_back({d, a[25:16], 16'h0, 16'h0030});
			run(fsh_pkg::OP_ERASE, a, 16'h0);
			chk_q();
			wb(1'b0, fsh_pkg::REG_STATUS, 32'h0, rd);
			check("busy pin", 64'(rd), 64'h0);
			run(fsh_pkg::OP_RESET, a, 16'h0);
			wb(1'b0, fsh_pkg::REG_STATUS, 32'h0, rd);
			check("reset stop", 64'(rd), 64'h2);
			w = 16'($urandom()) | 16'h0100;
			exp_q.push_back({d, a[25:0], w});
			exp_q.push_back({d, 15'h0, 11'h555, 16'h0090});
			run(fsh_pkg::OP_CMD_WR, a, w);
			run(fsh_pkg::OP_CMD_WR, 27'h555, 16'h0090);
			for (int k = 0; k < 6; k++) begin
				run(fsh_pkg::OP_DIE_RD, {1'b0, a[25:16], 8'h0, io[k]}, 16'h0);
				wb(1'b0, fsh_pkg::REG_RDATA, 32'h0, rd);
				check("id", 64'(rd), 64'(idv(io[k], a[16])));
			end
			exp_q.push_back({d, 15'h0, 11'h555, 16'h00f0});
			run(fsh_pkg::OP_CMD_WR, 27'h555, 16'h00f0);
			chk_q();
			$display("test die %0d done", i);
		end
		d = 1'b0;
		for (int i = 0; i < 4; i++) begin
			a = 27'($urandom());
			run(fsh_pkg::OP_ARRAY_RD, a, 16'h0);
			wb(1'b0, fsh_pkg::REG_RDATA, 32'h0, rd);
			check("array", 64'(rd), 64'(a[15:0] ^ {5'h0, a[26:16]}));
		end
		$display("test array done");
		report_and_stop();
	end
endmodule
`default_nettype wire
